// ---- rtl/dpsc_decoder.sv ----
// Serial command decoder of a 256-tap volatile digital potentiometer
//
// Overview of operation
// - Write-only port: chip select, data, clock
// - Shift data bit on each falling clock
// - Complete frame executes, tap updates at once
// - Early chip select rise discards partial frame
// - Power-on loads tap register with midscale
// - Set-tap stores data unless shutdown active
// - Tap code linear, zero bottom, full top
// - Resume clears shutdown, reconnects, restores tap
// - Resume leaves pump state unchanged
// - Open top, keep tap, enter shutdown
// - Open top, force zero, mid or full
// - Open bottom, keep tap, enter shutdown
// - Open bottom, force zero, mid or full
// - Open tap node, position follows register
// - Set-tap ignored during any shutdown
// - Clearing shutdown reconnects and restores tap
// - Opening commands leave pump state alone
// - Pump-enable turns pump on; on at power-on
// - Pump-disable turns pump off, low power
// - Soft reset restores all power-on defaults
`timescale 1ns/100ps

module dpsc_decoder #(
  parameter int FRAME_BITS = dpsc_pkg::FRAME_BITS
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_din,
  output      logic [7:0]           tap_code,
  output      dpsc_pkg::dpsc_term_s term_open,
  output      logic                 pump_enable
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (FRAME_BITS != dpsc_pkg::FRAME_BITS)
    begin : g_bad_frame
      $error("dpsc_decoder supports only a sixteen bit frame");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Tap code driven to the ladder for a mode and stored position
  function automatic logic [7:0] eff_tap(input dpsc_pkg::dpsc_mode_e mode,
                                         input logic [7:0]           pos);
    logic [7:0] res;
    res = pos;
    unique case (mode)
      dpsc_pkg::MODE_OPEN_TOP_WITH_ZERO,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_ZERO: res = dpsc_pkg::TAP_ZERO;
      dpsc_pkg::MODE_OPEN_TOP_WITH_MID,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_MID:  res = dpsc_pkg::TAP_MID;
      dpsc_pkg::MODE_OPEN_TOP_WITH_FULL,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_FULL: res = dpsc_pkg::TAP_FULL;
      default:                              res = pos;
    endcase
    return res;
  endfunction : eff_tap

  // Terminal open controls for a mode
  function automatic dpsc_pkg::dpsc_term_s eff_term(input dpsc_pkg::dpsc_mode_e mode);
    dpsc_pkg::dpsc_term_s t;
    t = '0;
    unique case (mode)
      dpsc_pkg::MODE_OPEN_TOP_KEEP_TAP,
      dpsc_pkg::MODE_OPEN_TOP_WITH_ZERO,
      dpsc_pkg::MODE_OPEN_TOP_WITH_MID,
      dpsc_pkg::MODE_OPEN_TOP_WITH_FULL:    t.top_open = 1'b1;
      dpsc_pkg::MODE_OPEN_BOTTOM_KEEP_TAP,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_ZERO,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_MID,
      dpsc_pkg::MODE_OPEN_BOTTOM_WITH_FULL: t.bottom_open = 1'b1;
      dpsc_pkg::MODE_OPEN_TAP_NODE:         t.tap_open = 1'b1;
      default:                              t = '0;
    endcase
    return t;
  endfunction : eff_term

  // ----------------------------------------------------------------
  // Link domain: shift register on the falling serial clock
  // ----------------------------------------------------------------
  dpsc_pkg::dpsc_link_s lk_q;
  dpsc_pkg::dpsc_link_s lk_d;

  // Next link state: shift MSB first, latch frame on sixteenth edge
  always_comb
  begin
    lk_d       = lk_q;
    lk_d.shift = {lk_q.shift[FRAME_BITS-2:0], spi_din};
    lk_d.count = lk_q.count + 1'b1;
    lk_d.done  = (lk_q.count == dpsc_pkg::LAST_BIT);
    if (lk_q.count == dpsc_pkg::LAST_BIT)
    begin
      lk_d.frame = {lk_q.shift[FRAME_BITS-2:0], spi_din};
    end
  end

  // Chip select high clears the bit count at once, dropping a partial frame
  always_ff @(negedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      lk_q.count <= '0;
    end
    else
    begin
      lk_q <= lk_d;
    end
  end

  // ----------------------------------------------------------------
  // Control domain: crossing, decode and tap state
  // ----------------------------------------------------------------
  // Synchroniser and seen flag start as if a done level were already taken,
  // so a done level left high by the last frame cannot run it again after reset
  localparam dpsc_pkg::dpsc_ctrl_s CTRL_RST = '{
    sync:         3'h7,
    seen:         1'b1,
    tap_position: dpsc_pkg::TAP_MID,
    mode:         dpsc_pkg::MODE_NONE,
    pump:         dpsc_pkg::PUMP_RST,
    tap_code:     dpsc_pkg::TAP_MID,
    term:         '0
  };

  dpsc_pkg::dpsc_ctrl_s st_q;
  dpsc_pkg::dpsc_ctrl_s st_d;
  logic                 agree;
  logic                 exec;
  logic [7:0]           cmd_b;
  logic [7:0]           data_b;

  // Frame done level counts once the second and third stages agree
  assign agree  = (st_q.sync[1] == st_q.sync[2]);
  assign exec   = agree && st_q.sync[2] && !st_q.seen;
  assign cmd_b  = lk_q.frame[dpsc_pkg::CMD_MSB:dpsc_pkg::CMD_LSB];
  assign data_b = lk_q.frame[dpsc_pkg::DATA_MSB:dpsc_pkg::DATA_LSB];

  // Next control state
  always_comb
  begin
    st_d      = st_q;
    st_d.sync = {st_q.sync[1:0], lk_q.done};
    if (agree)
    begin
      st_d.seen = st_q.sync[2];
    end
    if (exec)
    begin
      unique case (cmd_b)
        dpsc_pkg::CMD_SET_TAP:
        begin
          if (st_q.mode == dpsc_pkg::MODE_NONE)
          begin
            st_d.tap_position = data_b;
          end
        end
        dpsc_pkg::CMD_RESUME:       st_d.mode = dpsc_pkg::MODE_NONE;
        dpsc_pkg::CMD_TOP_KEEP:     st_d.mode = dpsc_pkg::MODE_OPEN_TOP_KEEP_TAP;
        dpsc_pkg::CMD_TOP_ZERO:     st_d.mode = dpsc_pkg::MODE_OPEN_TOP_WITH_ZERO;
        dpsc_pkg::CMD_TOP_MID:      st_d.mode = dpsc_pkg::MODE_OPEN_TOP_WITH_MID;
        dpsc_pkg::CMD_TOP_FULL:     st_d.mode = dpsc_pkg::MODE_OPEN_TOP_WITH_FULL;
        dpsc_pkg::CMD_BOT_KEEP:     st_d.mode = dpsc_pkg::MODE_OPEN_BOTTOM_KEEP_TAP;
        dpsc_pkg::CMD_BOT_ZERO:     st_d.mode = dpsc_pkg::MODE_OPEN_BOTTOM_WITH_ZERO;
        dpsc_pkg::CMD_BOT_MID:      st_d.mode = dpsc_pkg::MODE_OPEN_BOTTOM_WITH_MID;
        dpsc_pkg::CMD_BOT_FULL:     st_d.mode = dpsc_pkg::MODE_OPEN_BOTTOM_WITH_FULL;
        dpsc_pkg::CMD_TAP_NODE:     st_d.mode = dpsc_pkg::MODE_OPEN_TAP_NODE;
        dpsc_pkg::CMD_PUMP_DISABLE: st_d.pump = 1'b0;
        dpsc_pkg::CMD_PUMP_ENABLE:  st_d.pump = 1'b1;
        dpsc_pkg::CMD_SOFT_RESET:
        begin
          st_d.tap_position = dpsc_pkg::TAP_MID;
          st_d.mode         = dpsc_pkg::MODE_NONE;
          st_d.pump         = 1'b1;
        end
        default:
        begin
          st_d.mode = st_q.mode;
        end
      endcase
    end
    // Opening commands replace any earlier mode and never touch the pump
    // Registered ladder controls follow the new mode and position
    st_d.tap_code = eff_tap(st_d.mode, st_d.tap_position);
    st_d.term     = eff_term(st_d.mode);
  end

  // Control registers with synchronous power-on reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q <= CTRL_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign tap_code    = st_q.tap_code;
  assign term_open   = st_q.term;
  assign pump_enable = st_q.pump;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // Count wrapping from the sixteenth edge leaves the done level raised
  property p_frame_done;
    @(posedge spi_sclk) disable iff (spi_cs_n)
    (lk_q.count == '0) && $past(lk_q.count == dpsc_pkg::LAST_BIT) |-> lk_q.done;
  endproperty
  a_frame_done: assert property (p_frame_done)
    else $error("done not raised after sixteenth edge");

  // Power-on defaults after reset release
  property p_por;
    @(posedge ref_clk)
    $fell(sys_rst) |-> (st_q.tap_position == dpsc_pkg::TAP_MID) && pump_enable
                       && (tap_code == dpsc_pkg::TAP_MID) && (term_open == '0);
  endproperty
  a_por: assert property (p_por)
    else $error("power-on defaults wrong");

  // Execution is a single-cycle event
  property p_exec_once;
    @(posedge ref_clk) disable iff (sys_rst)
    exec |=> !exec [*2];
  endproperty
  a_exec_once: assert property (p_exec_once)
    else $error("frame executed twice");

  // Accepted tap write reaches register and ladder next cycle
  property p_tap_write;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_SET_TAP && st_q.mode == dpsc_pkg::MODE_NONE)
    |=> (st_q.tap_position == $past(data_b)) && (tap_code == $past(data_b));
  endproperty
  a_tap_write: assert property (p_tap_write)
    else $error("tap write not applied");

  // Tap write during shutdown leaves the register alone
  property p_tap_blocked;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_SET_TAP && st_q.mode != dpsc_pkg::MODE_NONE)
    |=> $stable(st_q.tap_position) && (st_q.mode == $past(st_q.mode));
  endproperty
  a_tap_blocked: assert property (p_tap_blocked)
    else $error("tap written during shutdown");

  // Resume reconnects all terminals and restores the stored tap
  property p_resume;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_RESUME)
    |=> (term_open == '0) && (tap_code == st_q.tap_position) && $stable(pump_enable);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not restore");

  // Forced midscale with top open, register untouched
  property p_top_mid;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_TOP_MID)
    |=> term_open.top_open && !term_open.bottom_open
        && (tap_code == dpsc_pkg::TAP_MID) && $stable(st_q.tap_position);
  endproperty
  a_top_mid: assert property (p_top_mid)
    else $error("top open with mid wrong");

  // Bottom open keeps the stored tap and the pump state
  property p_bot_keep;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_BOT_KEEP)
    |=> term_open.bottom_open && (tap_code == st_q.tap_position) && $stable(pump_enable);
  endproperty
  a_bot_keep: assert property (p_bot_keep)
    else $error("bottom open keep tap wrong");

  // Bottom open with full scale
  property p_bot_full;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_BOT_FULL)
    |=> term_open.bottom_open && (tap_code == dpsc_pkg::TAP_FULL);
  endproperty
  a_bot_full: assert property (p_bot_full)
    else $error("bottom open with full wrong");

  // Tap node open while position follows the register
  property p_tap_node;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_TAP_NODE)
    |=> term_open.tap_open && !term_open.top_open && (tap_code == st_q.tap_position);
  endproperty
  a_tap_node: assert property (p_tap_node)
    else $error("tap node open wrong");

  // Pump commands
  property p_pump_off;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_PUMP_DISABLE) |=> !pump_enable ##1 !pump_enable;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("pump not disabled");

  property p_pump_on;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_PUMP_ENABLE) |=> pump_enable;
  endproperty
  a_pump_on: assert property (p_pump_on)
    else $error("pump not enabled");

  // Soft reset restores defaults even from shutdown
  property p_soft_reset;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_SOFT_RESET)
    |=> (tap_code == dpsc_pkg::TAP_MID) && pump_enable && (term_open == '0)
        && (st_q.mode == dpsc_pkg::MODE_NONE);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset incomplete");

  // Without a frame nothing changes
  property p_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
    !exec |=> $stable(st_q.tap_position) && $stable(st_q.mode) && $stable(pump_enable);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("state changed without a frame");

  // Each falling edge shifts the data line into the low bit
  property p_shift_in;
    @(negedge spi_sclk) disable iff (spi_cs_n)
    !spi_cs_n |=> (lk_q.shift[0] == $past(spi_din));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("data bit not shifted in");

  // Top open keeping the stored tap
  property p_top_keep;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_TOP_KEEP)
    |=> term_open.top_open && !term_open.bottom_open && !term_open.tap_open
        && (tap_code == st_q.tap_position) && (st_q.mode != dpsc_pkg::MODE_NONE);
  endproperty
  a_top_keep: assert property (p_top_keep)
    else $error("top open keep tap wrong");

  // Top open with zero scale, register untouched
  property p_top_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_TOP_ZERO)
    |=> term_open.top_open && (tap_code == dpsc_pkg::TAP_ZERO) && $stable(st_q.tap_position);
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("top open with zero wrong");

  // A new opening command replaces the active shutdown mode
  property p_replace;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b == dpsc_pkg::CMD_TOP_FULL && st_q.mode != dpsc_pkg::MODE_NONE)
    |=> (st_q.mode == dpsc_pkg::MODE_OPEN_TOP_WITH_FULL) && (tap_code == dpsc_pkg::TAP_FULL);
  endproperty
  a_replace: assert property (p_replace)
    else $error("opening command did not replace mode");

  // Only pump and soft reset commands may move the pump enable
  property p_pump_kept;
    @(posedge ref_clk) disable iff (sys_rst)
    (exec && cmd_b != dpsc_pkg::CMD_PUMP_DISABLE && cmd_b != dpsc_pkg::CMD_PUMP_ENABLE
     && cmd_b != dpsc_pkg::CMD_SOFT_RESET) |=> $stable(pump_enable);
  endproperty
  a_pump_kept: assert property (p_pump_kept)
    else $error("pump state changed by other command");

endmodule : dpsc_decoder

// ---- rtl/dpsc_pkg.sv ----
// Constants, modes and carrier types of the serial potentiometer command decoder
package dpsc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int         FRAME_BITS = 16;            // Command byte then data byte
  localparam int         CNT_W      = 4;             // Bit counter width
  localparam logic [3:0] LAST_BIT   = 4'hF;          // Count value at sixteenth edge
  localparam int         CMD_MSB    = 15;
  localparam int         CMD_LSB    = 8;
  localparam int         DATA_MSB   = 7;
  localparam int         DATA_LSB   = 0;

  // ----------------------------------------------------------------
  // Tap codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TAP_ZERO  = 8'h00;          // Nearest bottom terminal
  localparam logic [7:0] TAP_MID   = 8'h80;          // Midscale, power-on value
  localparam logic [7:0] TAP_FULL  = 8'hFF;          // Nearest top terminal
  localparam logic       PUMP_RST  = 1'b1;           // Pump on after power-on

  // ----------------------------------------------------------------
  // Command byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_TAP         = 8'h00;
  localparam logic [7:0] CMD_RESUME          = 8'h80;
  localparam logic [7:0] CMD_BOT_KEEP        = 8'h88;
  localparam logic [7:0] CMD_BOT_ZERO        = 8'h89;
  localparam logic [7:0] CMD_BOT_MID         = 8'h8A;
  localparam logic [7:0] CMD_BOT_FULL        = 8'h8B;
  localparam logic [7:0] CMD_TAP_NODE        = 8'h8C;
  localparam logic [7:0] CMD_TOP_KEEP        = 8'h90;
  localparam logic [7:0] CMD_TOP_ZERO        = 8'h91;
  localparam logic [7:0] CMD_TOP_MID         = 8'h92;
  localparam logic [7:0] CMD_TOP_FULL        = 8'h93;
  localparam logic [7:0] CMD_PUMP_DISABLE    = 8'hA0;
  localparam logic [7:0] CMD_PUMP_ENABLE     = 8'hA1;
  localparam logic [7:0] CMD_SOFT_RESET      = 8'hC0;

  // ----------------------------------------------------------------
  // Shutdown modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    MODE_NONE                  = 10'h001,
    MODE_OPEN_TOP_KEEP_TAP     = 10'h002,
    MODE_OPEN_TOP_WITH_ZERO    = 10'h004,
    MODE_OPEN_TOP_WITH_MID     = 10'h008,
    MODE_OPEN_TOP_WITH_FULL    = 10'h010,
    MODE_OPEN_BOTTOM_KEEP_TAP  = 10'h020,
    MODE_OPEN_BOTTOM_WITH_ZERO = 10'h040,
    MODE_OPEN_BOTTOM_WITH_MID  = 10'h080,
    MODE_OPEN_BOTTOM_WITH_FULL = 10'h100,
    MODE_OPEN_TAP_NODE         = 10'h200
  } dpsc_mode_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic top_open;
    logic bottom_open;
    logic tap_open;
  } dpsc_term_s;

  typedef struct packed {
    logic [CNT_W-1:0]      count;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] frame;
    logic                  done;
  } dpsc_link_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       seen;
    logic [7:0] tap_position;
    dpsc_mode_e mode;
    logic       pump;
    logic [7:0] tap_code;
    dpsc_term_s term;
  } dpsc_ctrl_s;

endpackage : dpsc_pkg

// ---- verif/dpsc_host_model.sv ----
// Serial host model that frames command and data bytes onto the three-wire link
`timescale 1ns/100ps

module dpsc_host_model #(
  parameter int HALF_NS = 16,                  // Half of the 32 ns link clock period
  parameter int GAP_NS  = 200                  // Chip select high time between frames
) (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din
);

  // ----------------------------------------------------------------
  // Idle levels: link clock parked high, chip select released
  // ----------------------------------------------------------------
  initial
  begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b0;
    spi_din  = 1'b0;
    #1;
    spi_cs_n = 1'b1;                           // Clean rise clears the bit count
  end

  // ----------------------------------------------------------------
  // One frame; fewer than sixteen bits makes an aborted frame
  // ----------------------------------------------------------------
  task automatic send_frame(
    input logic [15:0] frame,
    input int          nbits
  );
    int i;
    #3;                                        // Offsets link edges from the control clock
    spi_cs_n = 1'b0;
    #(HALF_NS);
    for (i = 0; i < nbits; i++)
    begin
      spi_din = frame[15-i];
      #(HALF_NS);
      spi_sclk = 1'b0;
      #(HALF_NS);
      spi_sclk = 1'b1;
    end
    #(HALF_NS);
    spi_cs_n = 1'b1;
    spi_din  = ~spi_din;                       // Released line shows no stale bit
    #(GAP_NS);
  endtask : send_frame

endmodule : dpsc_host_model

// ---- verif/digipot_spi_command_decoder_test.sv ----
// Self-checking testbench of the serial potentiometer command decoder
`timescale 1ns/100ps

module digipot_spi_command_decoder_test;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] tap;
    logic [2:0] term;
    logic       pump;
  } dpsc_row_s;

  logic                 ref_clk;
  logic                 sys_rst;
  logic                 spi_sclk;
  logic                 spi_cs_n;
  logic                 spi_din;
  logic [7:0]           tap_code;
  dpsc_pkg::dpsc_term_s term_open;
  logic                 pump_enable;
  int                   err_count;
  int                   samples_checked;
  int                   k;

  // ----------------------------------------------------------------
  // Command rows with the state they should leave; term is {top,bottom,tap}
  // ----------------------------------------------------------------
  localparam dpsc_row_s ROWS [23] = '{
    '{8'h00, 8'h3C, 8'h3C, 3'h0, 1'b1},
    '{8'h00, 8'h00, 8'h00, 3'h0, 1'b1},
    '{8'h00, 8'hFF, 8'hFF, 3'h0, 1'b1},
    '{8'h90, 8'hA5, 8'hFF, 3'h4, 1'b1},
    '{8'h00, 8'h11, 8'hFF, 3'h4, 1'b1},
    '{8'h91, 8'hA5, 8'h00, 3'h4, 1'b1},
    '{8'h92, 8'hA5, 8'h80, 3'h4, 1'b1},
    '{8'h93, 8'hA5, 8'hFF, 3'h4, 1'b1},
    '{8'h80, 8'hA5, 8'hFF, 3'h0, 1'b1},
    '{8'hA0, 8'hA5, 8'hFF, 3'h0, 1'b0},
    '{8'h88, 8'hA5, 8'hFF, 3'h2, 1'b0},
    '{8'h89, 8'hA5, 8'h00, 3'h2, 1'b0},
    '{8'h8A, 8'hA5, 8'h80, 3'h2, 1'b0},
    '{8'h8B, 8'hA5, 8'hFF, 3'h2, 1'b0},
    '{8'h8C, 8'hA5, 8'hFF, 3'h1, 1'b0},
    '{8'h80, 8'hA5, 8'hFF, 3'h0, 1'b0},
    '{8'h55, 8'h12, 8'hFF, 3'h0, 1'b0},
    '{8'hA1, 8'hA5, 8'hFF, 3'h0, 1'b1},
    '{8'h00, 8'h5A, 8'h5A, 3'h0, 1'b1},
    '{8'h90, 8'hA5, 8'h5A, 3'h4, 1'b1},
    '{8'hC0, 8'hA5, 8'h80, 3'h0, 1'b1},
    '{8'hA0, 8'hA5, 8'h80, 3'h0, 1'b0},
    '{8'hC0, 8'hA5, 8'h80, 3'h0, 1'b1}
  };

  // ----------------------------------------------------------------
  // Clock, design and far-side host
  // ----------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  dpsc_decoder #(
    .FRAME_BITS (dpsc_pkg::FRAME_BITS)
  ) dut (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_din     (spi_din),
    .tap_code    (tap_code),
    .term_open   (term_open),
    .pump_enable (pump_enable)
  );

  dpsc_host_model u_host (
    .spi_sclk (spi_sclk),
    .spi_cs_n (spi_cs_n),
    .spi_din  (spi_din)
  );

  // ----------------------------------------------------------------
  // Comparison and closing tasks
  // ----------------------------------------------------------------
  task automatic check_out(
    input logic [7:0] exp_tap,
    input logic [2:0] exp_term,
    input logic       exp_pump
  );
    logic [11:0] exp_v;
    logic [11:0] got_v;
    exp_v = {exp_tap, exp_term, exp_pump};
    got_v = {tap_code, term_open, pump_enable};
    samples_checked++;
    if (got_v !== exp_v)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : check_out

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Sends a frame, then lets the synchroniser and output register settle
  task automatic frame_step(
    input logic [7:0] cmd,
    input logic [7:0] data,
    input int         nbits
  );
    u_host.send_frame({cmd, data}, nbits);
    @(posedge ref_clk);
    #1;
  endtask : frame_step

  // ----------------------------------------------------------------
  // Watchdog against a hung run
  // ----------------------------------------------------------------
  initial
  begin
    #300000;
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_count       = 0;
    samples_checked = 0;
    sys_rst         = 1'b1;
    repeat (7) @(posedge ref_clk);
    #1;
    check_out(8'h80, 3'h0, 1'b1);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check_out(8'h80, 3'h0, 1'b1);
    // Table of ordinary commands, each row building on the one before
    for (k = 0; k < 23; k++)
    begin
      frame_step(ROWS[k].cmd, ROWS[k].data, 16);
      check_out(ROWS[k].tap, ROWS[k].term, ROWS[k].pump);
    end
    // Aborted frame one bit short changes nothing
    frame_step(8'h00, 8'h12, 15);
    check_out(8'h80, 3'h0, 1'b1);
    // Full frame right after an abort starts from a clean count
    frame_step(8'h00, 8'hC3, 16);
    check_out(8'hC3, 3'h0, 1'b1);
    // Abort of an opening command leaves terminals connected
    frame_step(8'h91, 8'hA5, 9);
    check_out(8'hC3, 3'h0, 1'b1);
    // Reset in mid-run from a shutdown with the pump off
    frame_step(8'h89, 8'hA5, 16);
    frame_step(8'hA0, 8'hA5, 16);
    check_out(8'h00, 3'h2, 1'b0);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check_out(8'h80, 3'h0, 1'b1);
    frame_step(8'h00, 8'h01, 16);
    check_out(8'h01, 3'h0, 1'b1);
    test_done();
  end

endmodule : digipot_spi_command_decoder_test
